// File: design/sxd_count_join.sv
`include "sxd_map.svh"
`default_nettype none
// ----------------------------------------------------------------
// rebuilds buffer entry count minus one from the three size fields
// ----------------------------------------------------------------
module sxd_count_join
  import sxd_pkg::*;
(
  input  wire logic [13:0] height_f,
  input  wire logic [13:0] width_f,
  input  wire logic [10:0] depth_f,
  input  wire logic        is_struct,
  input  wire logic        is_raw,
  output logic [30:0]      count_m1
);
  logic [9:0] dep_slice;
  // depth slice width depends on buffer flavour
  always_comb
  begin
    if (is_struct)
      dep_slice = {4'h0, depth_f[5:0]};                  // RULE_06
    else if (is_raw)
      dep_slice = depth_f[9:0];                          // RULE_04
    else
      dep_slice = {3'h0, depth_f[6:0]};                  // RULE_05
    count_m1 = {dep_slice, height_f, width_f[6:0]};      // RULE_02 RULE_03
  end
endmodule
`default_nettype wire

// File: design/sxd_extent_decoder.sv
// Functional notes
// RULE_01: non-buffer height field is base height minus one; line surfaces hold zero.
// RULE_02: buffer height field carries entry-count-minus-one bits 20 to 7.
// RULE_03: buffer width low seven bits carry entry-count-minus-one bits 6 to 0.
// RULE_04: raw plain buffer depth carries bits 30 to 21.
// RULE_05: non-raw plain buffer depth carries bits 27 to 21.
// RULE_06: structured buffer depth carries bits 26 to 21.
// RULE_07: software splits count minus one right-justified, upper bits cleared.
// RULE_08: raw buffer entries count bytes, up to two to the thirtieth; the decoder takes counts up to two to the thirty-first.
// RULE_09: with line stride one, height means one field, not frame.
// RULE_10: software keeps stride-0 height even when both strides used.
// RULE_11: software keeps height even for non-normal pixel boundary mode.
// RULE_12: width is width minus one; volumes to 2048, others 16384.
// RULE_13: media block width in doublewords; enhancement two-plane output uses words.
// RULE_14: software keeps width within pitch; cube width equals height.
// RULE_15: software: mono textures width multiple of 32, luma-chroma targets of 2.
// RULE_16: software sets width low bits to one for raw buffers.
// RULE_17: depth is volume depth or array count minus one.
// RULE_18: sampler cube depth counts cube elements up to 340; else zero.
// RULE_19: software limits sampler cube depth to 85.
// RULE_20: software keeps plain buffer depth to 63 unless raw one-byte pitch.
// RULE_21: pitch is bytes minus one; buffers use structure size to 2048.
// RULE_22: software keeps tiled and linear pitch ranges.
// RULE_23: reserved descriptor bits are ignored.
`include "sxd_map.svh"
`default_nettype none
module sxd_extent_decoder
  import sxd_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        DESC_VALID,
  input  wire logic [5:0]  SURFACE_KIND,
  input  wire logic        RAW_FORMAT,
  input  wire logic        SAMPLER_USE,
  input  wire logic        LINE_STRIDE_ONE,
  input  wire logic        MEDIA_BLOCK,
  input  wire logic        ENHANCE_TWO_PLANE,
  input  wire logic [31:0] HW_WORD,
  input  wire logic [31:0] DP_WORD,
  output logic             EXT_VALID,
  output logic             IS_BUFFER,
  output logic [14:0]      EXT_HEIGHT,
  output logic             HEIGHT_IS_FIELD,
  output logic [14:0]      EXT_WIDTH,
  output logic [1:0]       WIDTH_UNIT,
  output logic [11:0]      EXT_DEPTH,
  output logic [18:0]      EXT_PITCH,
  output logic [31:0]      BUF_ENTRIES,
  output logic             RANGE_ERR
);
  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  logic [13:0] height_f;
  logic [13:0] width_f;
  logic [10:0] depth_f;
  logic [17:0] pitch_f;
  logic [30:0] count_m1;
  logic        is_buf;
  logic        is_struct;

  // reserved bits 15:14 and 20:18 are simply never selected
  assign height_f  = HW_WORD[`SXD_HEIGHT_HI:`SXD_HEIGHT_LO];  // RULE_23
  assign width_f   = HW_WORD[`SXD_WIDTH_HI:`SXD_WIDTH_LO];
  assign depth_f   = DP_WORD[`SXD_DEPTH_HI:`SXD_DEPTH_LO];
  assign pitch_f   = DP_WORD[`SXD_PITCH_HI:`SXD_PITCH_LO];    // RULE_23
  assign is_struct = (SURFACE_KIND == SXD_KIND_STRUCT);
  assign is_buf    = (SURFACE_KIND == SXD_KIND_PLAIN) || is_struct;

  sxd_count_join u_join (
    .height_f  (height_f),
    .width_f   (width_f),
    .depth_f   (depth_f),
    .is_struct (is_struct),
    .is_raw    (RAW_FORMAT && !is_struct),
    .count_m1  (count_m1)
  );

  // add one to a minus-one field
  function automatic logic [14:0] plus_one14(input logic [13:0] v);
    plus_one14 = {1'b0, v} + 15'h0001;
  endfunction

  // ----------------------------------------------------------------
  // next-value logic
  // ----------------------------------------------------------------
  logic        valid_d, valid_q;
  logic        isbuf_d, isbuf_q;
  logic [14:0] height_d, height_q;
  logic        field_d, field_q;
  logic [14:0] width_d, width_q;
  logic [1:0]  unit_d, unit_q;
  logic [11:0] depth_d, depth_q;
  logic [18:0] pitch_d, pitch_q;
  logic [31:0] entries_d, entries_q;
  logic        err_d, err_q;

  // decoded extents are counts, not minus-one values
  always_comb
  begin
    valid_d   = DESC_VALID;
    isbuf_d   = isbuf_q;
    height_d  = height_q;
    field_d   = field_q;
    width_d   = width_q;
    unit_d    = unit_q;
    depth_d   = depth_q;
    pitch_d   = pitch_q;
    entries_d = entries_q;
    err_d     = 1'b0;
    if (DESC_VALID)
    begin
      // buffer flag is an extent too: it only moves on a taken decode
      isbuf_d   = is_buf;
      entries_d = {1'b0, count_m1} + 32'h0000_0001;       // RULE_02 RULE_08
      field_d   = LINE_STRIDE_ONE && !is_buf;              // RULE_09
      pitch_d   = {1'b0, pitch_f} + 19'h00001;             // RULE_21
      depth_d   = {1'b0, depth_f} + 12'h001;               // RULE_17
      if (MEDIA_BLOCK)
        unit_d = ENHANCE_TWO_PLANE ? `SXD_WIDTH_UNIT_W : `SXD_WIDTH_UNIT_DW; // RULE_13
      else
        unit_d = `SXD_WIDTH_UNIT_PX;
      if (is_buf)
      begin
        height_d = 15'h0001;
        width_d  = 15'h0001;
        depth_d  = 12'h001;
        if (pitch_f > `SXD_STRUCT_MAX)
          err_d = 1'b1;                                    // RULE_21
      end
      else
      begin
        height_d = plus_one14(height_f);                   // RULE_01
        width_d  = plus_one14(width_f);                    // RULE_12
        case (SURFACE_KIND)
          SXD_KIND_LINE:
          begin
            height_d = 15'h0001;                           // RULE_01
            if (height_f != 14'h0000)
              err_d = 1'b1;
          end
          SXD_KIND_VOLUME:
          begin
            if (width_f > `SXD_VOL_WIDTH_MAX)
              err_d = 1'b1;                                // RULE_12
          end
          SXD_KIND_SIXFACE:
          begin
            // sampler counts whole cubes of six slices
            if (SAMPLER_USE && depth_f > `SXD_CUBE_DEPTH_MAX)
              err_d = 1'b1;                                // RULE_18
            if (!SAMPLER_USE && depth_f != 11'h000)
              err_d = 1'b1;                                // RULE_18
          end
          SXD_KIND_PLANE:
            err_d = 1'b0;
          default:
            err_d = 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      valid_q   <= 1'b0;
      isbuf_q   <= 1'b0;
      height_q  <= 15'h0000;
      field_q   <= 1'b0;
      width_q   <= 15'h0000;
      unit_q    <= 2'h0;
      depth_q   <= 12'h000;
      pitch_q   <= 19'h00000;
      entries_q <= 32'h0000_0000;
      err_q     <= 1'b0;
    end
    else
    begin
      valid_q   <= valid_d;
      isbuf_q   <= isbuf_d;
      height_q  <= height_d;
      field_q   <= field_d;
      width_q   <= width_d;
      unit_q    <= unit_d;
      depth_q   <= depth_d;
      pitch_q   <= pitch_d;
      entries_q <= entries_d;
      err_q     <= err_d;
    end
  end

  assign EXT_VALID       = valid_q;
  assign IS_BUFFER       = isbuf_q;
  assign EXT_HEIGHT      = height_q;
  assign HEIGHT_IS_FIELD = field_q;
  assign EXT_WIDTH       = width_q;
  assign WIDTH_UNIT      = unit_q;
  assign EXT_DEPTH       = depth_q;
  assign EXT_PITCH       = pitch_q;
  assign BUF_ENTRIES     = entries_q;
  assign RANGE_ERR       = err_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_buf_count: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_06
    DESC_VALID && is_struct |=> BUF_ENTRIES ==
      {5'h00, $past(DP_WORD[26:21]), $past(HW_WORD[29:16]), $past(HW_WORD[6:0])} + 32'h1)
    else $error("struct buffer entry count wrong");
  // full count compare, so a carry out of the low slices is judged too
  chk_raw_count: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_04
    DESC_VALID && SURFACE_KIND == SXD_KIND_PLAIN && RAW_FORMAT |=> BUF_ENTRIES ==
      {1'b0, $past(DP_WORD[30:21]), $past(HW_WORD[29:16]), $past(HW_WORD[6:0])} + 32'h1)
    else $error("raw buffer entry count wrong");
  chk_plain_depth: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_05
    DESC_VALID && SURFACE_KIND == SXD_KIND_PLAIN && !RAW_FORMAT && !(&HW_WORD[29:16])
      |=> BUF_ENTRIES[30:28] == 3'h0)
    else $error("non-raw depth upper bits leaked");
  chk_height_val: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_01
    DESC_VALID && SURFACE_KIND == SXD_KIND_PLANE |=>
      EXT_HEIGHT == {1'b0, $past(HW_WORD[29:16])} + 15'h1)
    else $error("plane height wrong");
  chk_width_val: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_12
    DESC_VALID && !is_buf |=> EXT_WIDTH == {1'b0, $past(HW_WORD[13:0])} + 15'h1)
    else $error("width wrong");
  chk_vol_width: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_12
    DESC_VALID && SURFACE_KIND == SXD_KIND_VOLUME && HW_WORD[13:11] != 3'h0 |=> RANGE_ERR)
    else $error("wide volume not flagged");
  chk_cube_depth: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_18
    DESC_VALID && SURFACE_KIND == SXD_KIND_SIXFACE && SAMPLER_USE &&
      DP_WORD[31:21] > 11'h154 |=> RANGE_ERR)
    else $error("cube depth not flagged");
  chk_field_mode: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_09
    DESC_VALID |=> HEIGHT_IS_FIELD == ($past(LINE_STRIDE_ONE) && !IS_BUFFER))
    else $error("field mode wrong");
  chk_width_unit: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_13
    DESC_VALID && MEDIA_BLOCK && ENHANCE_TWO_PLANE |=> WIDTH_UNIT == 2'h1)
    else $error("word unit not chosen");
  chk_pitch_val: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_21
    DESC_VALID |=> EXT_PITCH == {1'b0, $past(DP_WORD[17:0])} + 19'h1)
    else $error("pitch wrong");
  chk_rsvd_ign: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_23
    DESC_VALID && $stable(HW_WORD[29:16]) && $stable(HW_WORD[13:0]) && $stable(DP_WORD[31:21])
      && $stable(DP_WORD[17:0]) && $past(DESC_VALID) && $stable(SURFACE_KIND)
      |=> $stable(EXT_HEIGHT) && $stable(EXT_PITCH))
    else $error("reserved bits changed output");
endmodule
`default_nettype wire

// File: design/sxd_map.svh
`ifndef SXD_MAP_SVH
`define SXD_MAP_SVH
// ----------------------------------------------------------------
// descriptor field positions
// ----------------------------------------------------------------
`define SXD_HEIGHT_HI      29
`define SXD_HEIGHT_LO      16
`define SXD_WIDTH_HI       13
`define SXD_WIDTH_LO       0
`define SXD_DEPTH_HI       31
`define SXD_DEPTH_LO       21
`define SXD_PITCH_HI       17
`define SXD_PITCH_LO       0
// ----------------------------------------------------------------
// entry count width, range limits and width unit codes
// ----------------------------------------------------------------
`define SXD_CNT_W          31
`define SXD_VOL_WIDTH_MAX  14'h07FF
`define SXD_CUBE_DEPTH_MAX 11'h154
`define SXD_STRUCT_MAX     18'h007FF
`define SXD_WIDTH_UNIT_DW  2'h0
`define SXD_WIDTH_UNIT_W   2'h1
`define SXD_WIDTH_UNIT_PX  2'h2
`endif

// File: design/sxd_pkg.sv
`default_nettype none
package sxd_pkg;
  // surface kinds, one-hot
  typedef enum logic [5:0] {
    SXD_KIND_LINE   = 6'h01,
    SXD_KIND_PLANE  = 6'h02,
    SXD_KIND_VOLUME = 6'h04,
    SXD_KIND_SIXFACE = 6'h08,
    SXD_KIND_PLAIN  = 6'h10,
    SXD_KIND_STRUCT = 6'h20
  } sxd_kind_t;
endpackage
`default_nettype wire

// File: sim/sxd_extent_decoder_tb.sv
`include "sxd_map.svh"
`default_nettype none
module sxd_extent_decoder_tb
  import sxd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        REF_CLK, RST_N, DESC_VALID, RAW_FORMAT, SAMPLER_USE, LINE_STRIDE_ONE;
  logic        MEDIA_BLOCK, ENHANCE_TWO_PLANE, EXT_VALID, IS_BUFFER, HEIGHT_IS_FIELD;
  logic        RANGE_ERR, use_m, pv, ok, e_b, e_f, e_r;
  logic [5:0]  SURFACE_KIND;
  logic [31:0] HW_WORD, DP_WORD, hw_r, dp_r, m_hw, m_dp, r, BUF_ENTRIES, e_n;
  logic [30:0] cnt;
  logic [14:0] EXT_HEIGHT, EXT_WIDTH, e_h, e_w;
  logic [11:0] EXT_DEPTH, e_d;
  logic [18:0] EXT_PITCH, e_p;
  logic [1:0]  WIDTH_UNIT, e_u;
  int          err_total, checks, seed, i;
  // boundary cases: kind, sampler use, height-width word, depth-pitch word;
  // the second repeats the first with only its reserved bits cleared
  logic [70:0] corner [0:10] = '{
    {6'h01, 1'b0, 32'h0000C000, 32'h001C0000}, {6'h01, 1'b0, 32'h0, 32'h0},
    {6'h01, 1'b0, 32'h00010000, 32'h0},
    {6'h04, 1'b0, 32'h000007FF, 32'h0}, {6'h04, 1'b0, 32'h00000800, 32'h0},
    {6'h08, 1'b1, 32'h0, 32'h2A800000}, {6'h08, 1'b1, 32'h0, 32'h2AA00000},
    {6'h08, 1'b0, 32'h0, 32'h00200000}, {6'h03, 1'b0, 32'h0, 32'h0},
    {6'h10, 1'b0, 32'h0, 32'h000007FF}, {6'h20, 1'b0, 32'h0, 32'h00000800}};

  assign HW_WORD = use_m ? m_hw : hw_r;
  assign DP_WORD = use_m ? m_dp : dp_r;

  sxd_sw_model sw (.cnt_m1(cnt), .kind(SURFACE_KIND), .raw(RAW_FORMAT),
    .pitch(dp_r[17:0]), .hw_word(m_hw), .dp_word(m_dp));

  sxd_extent_decoder dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .DESC_VALID(DESC_VALID),
    .SURFACE_KIND(SURFACE_KIND), .RAW_FORMAT(RAW_FORMAT), .SAMPLER_USE(SAMPLER_USE),
    .LINE_STRIDE_ONE(LINE_STRIDE_ONE), .MEDIA_BLOCK(MEDIA_BLOCK),
    .ENHANCE_TWO_PLANE(ENHANCE_TWO_PLANE), .HW_WORD(HW_WORD), .DP_WORD(DP_WORD),
    .EXT_VALID(EXT_VALID), .IS_BUFFER(IS_BUFFER), .EXT_HEIGHT(EXT_HEIGHT),
    .HEIGHT_IS_FIELD(HEIGHT_IS_FIELD), .EXT_WIDTH(EXT_WIDTH), .WIDTH_UNIT(WIDTH_UNIT),
    .EXT_DEPTH(EXT_DEPTH), .EXT_PITCH(EXT_PITCH), .BUF_ENTRIES(BUF_ENTRIES),
    .RANGE_ERR(RANGE_ERR));

  // ----------------------------------------------------------------
  // comparison, prediction and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // expectation worked out from the words as sent, one decode later
  task automatic predict();
    logic [10:0] d;
    d = dp_r[31:21];
    ok = $onehot(SURFACE_KIND);
    e_b = use_m;
    e_f = LINE_STRIDE_ONE & !use_m;
    e_u = !MEDIA_BLOCK ? `SXD_WIDTH_UNIT_PX
      : (ENHANCE_TWO_PLANE ? `SXD_WIDTH_UNIT_W : `SXD_WIDTH_UNIT_DW);
    e_h = (use_m || SURFACE_KIND == SXD_KIND_LINE) ? 15'h0001
      : 15'(hw_r[29:16]) + 15'h0001;
    e_w = use_m ? 15'h0001 : 15'(hw_r[13:0]) + 15'h0001;
    e_d = use_m ? 12'h001 : 12'(d) + 12'h001;
    e_p = 19'(dp_r[17:0]) + 19'h00001;
    e_n = 32'(cnt) + 32'h00000001;
    e_r = !ok || (SURFACE_KIND == SXD_KIND_LINE && hw_r[29:16] != 14'h0000)
      || (SURFACE_KIND == SXD_KIND_VOLUME && hw_r[13:0] > 14'h07FF)
      || (SURFACE_KIND == SXD_KIND_SIXFACE && (SAMPLER_USE ? d > 11'h154 : d != 11'h000))
      || (use_m && dp_r[17:0] > 18'h007FF);
  endtask

  task automatic check_out();
    chk(32'(EXT_VALID), 32'(pv));
    chk(32'(RANGE_ERR), 32'(pv & e_r));
    if (ok)
    begin
      chk(32'(IS_BUFFER), 32'(e_b));
      chk(32'(EXT_HEIGHT), 32'(e_h));
      chk(32'(EXT_WIDTH), 32'(e_w));
      chk(32'(EXT_DEPTH), 32'(e_d));
      chk(32'(EXT_PITCH), 32'(e_p));
      chk(32'(HEIGHT_IS_FIELD), 32'(e_f));
      chk(32'(WIDTH_UNIT), 32'(e_u));
      if (e_b)
        chk(BUF_ENTRIES, e_n);
    end
  endtask

  // holds reset five cycles; every output but BUF_ENTRIES must read zero at its end
  task automatic do_reset();
    RST_N = 1'b0;
    DESC_VALID = 1'b0;
    {pv, e_b, e_f, e_r, e_u, e_h, e_w, e_d, e_p, e_n} = '0;
    ok = 1'b1;
    repeat (5) @(negedge REF_CLK);
    check_out();
    RST_N = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  // the run needs about 620 cycles; ten times that means a hang
  initial
  begin
    #62000;
    err_total++;
    print_verdict();
  end

  // random traffic with corners first; back-to-back decodes are common
  initial
  begin
    seed = 57911;
    {err_total, checks} = '0;
    {RAW_FORMAT, SAMPLER_USE, LINE_STRIDE_ONE, MEDIA_BLOCK, ENHANCE_TWO_PLANE} = '0;
    {use_m, SURFACE_KIND, hw_r, dp_r, cnt} = '0;
    do_reset();
    for (i = 0; i < 600; i++)
    begin
      @(negedge REF_CLK);
      check_out();
      if (i == 300)
        do_reset();
      r = $random(seed);
      hw_r = $random(seed);
      dp_r = $random(seed);
      cnt = 31'($random(seed));
      SURFACE_KIND = 6'h01 << (r[2:0] % 3'h6);
      {ENHANCE_TWO_PLANE, MEDIA_BLOCK, LINE_STRIDE_ONE, SAMPLER_USE, RAW_FORMAT} = r[7:3];
      if (r[10])
        hw_r[29:16] = 14'h0000;
      if (r[11])
        dp_r[31:30] = 2'h0;
      if (r[12])
        dp_r[31:21] = 11'h000;
      if (r[13])
        dp_r[17:11] = 7'h00;
      // random traffic keeps the software rules; surfaces count as linear, so any pitch
      // not below the width is legal; corners break the rules on purpose to reach the checks
      if (!LINE_STRIDE_ONE || MEDIA_BLOCK)
        hw_r[16] = 1'b0;
      if (r[14] && SURFACE_KIND != SXD_KIND_SIXFACE)
        hw_r[4:0] = 5'h1F;
      if (SURFACE_KIND == SXD_KIND_SIXFACE)
        hw_r[13:0] = hw_r[29:16];
      if (!(SURFACE_KIND[4] | SURFACE_KIND[5]) && dp_r[17:0] < 18'(hw_r[13:0]))
        dp_r[17:0] = 18'(hw_r[13:0]);
      if (SURFACE_KIND == SXD_KIND_SIXFACE && SAMPLER_USE && dp_r[31:21] > 11'h055)
        dp_r[31:21] = 11'h055;
      // a one-byte raw pitch is the only way past depth 63
      if (SURFACE_KIND == SXD_KIND_PLAIN && RAW_FORMAT && r[16])
        dp_r[17:0] = 18'h00000;
      if (i < 11)
      begin
        {SURFACE_KIND, SAMPLER_USE, hw_r, dp_r} = corner[i];
        cnt = '1;
      end
      if (SURFACE_KIND == SXD_KIND_STRUCT)
        cnt[30:27] = 4'h0;
      else if (!RAW_FORMAT)
        cnt[30:28] = 3'h0;
      else
        cnt[1:0] = 2'h3;
      if (SURFACE_KIND == SXD_KIND_PLAIN && !(RAW_FORMAT && dp_r[17:0] == 18'h00000))
        cnt[30:27] = 4'h0;
      DESC_VALID = (i < 11) | r[8] | r[9];
      use_m = SURFACE_KIND[4] | SURFACE_KIND[5];
      if (DESC_VALID)
        predict();
      pv = DESC_VALID;
    end
    @(negedge REF_CLK);
    check_out();
    print_verdict();
  end
endmodule
`default_nettype wire

// File: sim/sxd_sw_model.sv
`default_nettype none
// ----------------------------------------------------------------
// driver software packing a buffer entry count into descriptor words
// ----------------------------------------------------------------
module sxd_sw_model
  import sxd_pkg::*;
(
  input  wire logic [30:0] cnt_m1,
  input  wire logic [5:0]  kind,
  input  wire logic        raw,
  input  wire logic [17:0] pitch,
  output logic [31:0]      hw_word,
  output logic [31:0]      dp_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] dslice;

  // slices right-justified, unused upper bits cleared; reserved bits left zero
  always_comb
  begin
    if (kind == SXD_KIND_STRUCT)
      dslice = {5'h00, cnt_m1[26:21]};
    else if (raw)
      dslice = {1'b0, cnt_m1[30:21]};
    else
      dslice = {4'h0, cnt_m1[27:21]};
    hw_word = {2'h0, cnt_m1[20:7], 9'h000, cnt_m1[6:0]};
    // raw buffers must be a whole number of 32-bit words
    if (raw && kind == SXD_KIND_PLAIN)
      hw_word[1:0] = 2'h3;
    dp_word = {dslice, 3'h0, pitch};
  end
endmodule
`default_nettype wire
